// File: hw/stoc_pkg.sv
package stoc_pkg;

    // ************************************************************
    // Geometry
    // ************************************************************
    localparam int STOC_AXES = 2;
    localparam int STOC_GUARDS = 6;

    // ************************************************************
    // Register offsets (byte addresses)
    // ************************************************************
    localparam logic [7:0] STOC_OFS_CTRL = 8'h00;
    localparam logic [7:0] STOC_OFS_MODE = 8'h04;
    localparam logic [7:0] STOC_OFS_BEHAV = 8'h08;
    localparam logic [7:0] STOC_OFS_STOPTIME = 8'h0C;
    localparam logic [7:0] STOC_OFS_STATUS = 8'h10;
    localparam logic [7:0] STOC_OFS_CFGERR = 8'h14;

    // ************************************************************
    // Field positions and reset values
    // ************************************************************
    localparam int STOC_CTRL_BOOT = 0;
    localparam int STOC_CTRL_BRK_FOLLOW0 = 1;
    localparam int STOC_CTRL_BRK_FOLLOW1 = 2;
    localparam int STOC_CTRL_RAMP_REACT0 = 3;
    localparam int STOC_CTRL_RAMP_REACT1 = 4;
    localparam logic [31:0] STOC_CTRL_RST = 32'h0000_0000;
    localparam logic [5:0] STOC_MODE_RST = 6'h00;
    localparam logic [5:0] STOC_BEHAV_RST = 6'h00;
    // Guard kinds with bit 3..5 being the watch-only variants.
    localparam logic [5:0] STOC_WATCH_ONLY_MASK = 6'h38;

    // ************************************************************
    // Timing
    // ************************************************************
    localparam int STOC_CLK_MHZ = 50;
    localparam int STOC_STOP_TIME_MS = 100;
    localparam int STOC_STOP_CYCLES = STOC_STOP_TIME_MS * 1000 * STOC_CLK_MHZ;

    // ************************************************************
    // Types
    // ************************************************************
    typedef enum logic [2:0] {
        STOC_DEV_STARTUP = 3'b001,
        STOC_DEV_RUN = 3'b010,
        STOC_DEV_TORQUE_OFF = 3'b100
    } stoc_dev_state_t;

    typedef enum logic [2:0] {
        STOC_AX_RUN = 3'b001,
        STOC_AX_STOPPING = 3'b010,
        STOC_AX_TORQUE_OFF = 3'b100
    } stoc_ax_state_t;

    typedef struct packed {
        logic torque_removal_request_in_n;
        logic controlled_stop_request_in_n;
        logic [5:0] guard_request_n;
        logic standstill;
        logic ramp_violation;
        logic [5:0] guard_in_limit;
        logic drive_brake_cmd;
        logic brake_test_running;
    } stoc_axis_in_t;

    typedef struct packed {
        logic torque_off_a;
        logic torque_off_b;
        logic torque_removal_ack_out;
        logic controlled_stop_ack_out;
        logic [5:0] guard_ok;
        logic brake_out;
        logic brake_test_active_out;
        logic [2:0] state;
    } stoc_axis_out_t;

endpackage

// File: hw/stoc_top.sv
`timescale 1ns/1ps
`default_nettype none

module stoc_top
    import stoc_pkg::*;
#(
    parameter int STOP_CYCLES = STOC_STOP_CYCLES
) (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // AXI4-Lite write address
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    // AXI4-Lite write data
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // AXI4-Lite write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // AXI4-Lite read address
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    // AXI4-Lite read data
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Error events from the device
    input wire logic global_error,
    input wire logic fatal_error,
    // Axis side, pins from the fieldbus and drive
    input wire stoc_axis_in_t axis_in [STOC_AXES],
    output stoc_axis_out_t axis_out [STOC_AXES],
    // Device state
    output logic [2:0] device_state
);

    // ************************************************************
    // Input synchronisers
    // ************************************************************
    localparam int AW = $bits(stoc_axis_in_t);
    logic [AW-1:0] in_s1_r [STOC_AXES];
    logic [AW-1:0] in_s2_r [STOC_AXES];
    logic [1:0] err_s1_r;
    logic [1:0] err_s2_r;

    // Pins pass two flops; only the second stage is read by logic.
    always_ff @(posedge aclk) begin
        for (int i = 0; i < STOC_AXES; i++) begin
            in_s1_r[i] <= axis_in[i];
            in_s2_r[i] <= in_s1_r[i];
        end
        err_s1_r <= {fatal_error, global_error};
        err_s2_r <= err_s1_r;
    end

    // ************************************************************
    // Registers
    // ************************************************************
    logic [31:0] ctrl_r;
    logic [5:0] mode_r;
    logic [5:0] behav_r;
    logic [31:0] stop_time_r;
    // Power-on value; only removing power brings the latch back to zero.
    logic fatal_r = 1'b0;

    // A permanent guard is legal only for the six motion and watch kinds,
    // and a permanent watch-only guard must be in hysteresis behaviour.
    wire [5:0] cfg_bad = mode_r & STOC_WATCH_ONLY_MASK & ~behav_r;
    wire cfg_ok = (cfg_bad == 6'h00);
    wire [5:0] perm_mask = cfg_ok ? mode_r : 6'h00;
    wire boot_done = ctrl_r[STOC_CTRL_BOOT];

    // ************************************************************
    // AXI4-Lite slave
    // ************************************************************
    logic aw_held_r;
    logic w_held_r;
    logic [7:0] aw_addr_r;
    logic [31:0] w_data_r;
    logic [3:0] w_strb_r;
    logic bvalid_r;
    logic rvalid_r;
    logic [31:0] rdata_r;
    logic [1:0] rresp_r;
    logic [1:0] bresp_r;

    assign s_axi_awready = !aw_held_r && !bvalid_r;
    assign s_axi_wready = !w_held_r && !bvalid_r;
    assign s_axi_arready = !rvalid_r;
    assign s_axi_bvalid = bvalid_r;
    assign s_axi_bresp = bresp_r;
    assign s_axi_rvalid = rvalid_r;
    assign s_axi_rdata = rdata_r;
    assign s_axi_rresp = rresp_r;

    wire aw_have = aw_held_r || s_axi_awvalid;
    wire w_have = w_held_r || s_axi_wvalid;
    wire wr_go = aw_have && w_have && !bvalid_r;
    wire [7:0] wr_addr = aw_held_r ? aw_addr_r : s_axi_awaddr;
    wire [31:0] wr_data = w_held_r ? w_data_r : s_axi_wdata;
    wire [3:0] wr_strb = w_held_r ? w_strb_r : s_axi_wstrb;
    wire wr_ctrl = wr_go && (wr_addr == STOC_OFS_CTRL);
    wire wr_mode = wr_go && (wr_addr == STOC_OFS_MODE);
    wire wr_behav = wr_go && (wr_addr == STOC_OFS_BEHAV);
    wire wr_time = wr_go && (wr_addr == STOC_OFS_STOPTIME);
    wire wr_hit = wr_ctrl || wr_mode || wr_behav || wr_time || (wr_addr == STOC_OFS_STATUS)
        || (wr_addr == STOC_OFS_CFGERR);
    // Mode and behaviour are frozen while the boot bit in CTRL is set.
    wire cfg_open = !boot_done;

    function automatic logic [31:0] stoc_merge(input logic [31:0] old, input logic [31:0] nw,
                                               input logic [3:0] strb);
        logic [31:0] res;
        res = old;
        for (int b = 0; b < 4; b++) begin
            if (strb[b]) res[b*8 +: 8] = nw[b*8 +: 8];
        end
        return res;
    endfunction

    wire [31:0] mode_m = stoc_merge({26'h0, mode_r}, wr_data, wr_strb);
    wire [31:0] behav_m = stoc_merge({26'h0, behav_r}, wr_data, wr_strb);

    // Write path: address and data may arrive in either order.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_r <= 1'b0;
            w_held_r <= 1'b0;
            aw_addr_r <= 8'h00;
            w_data_r <= 32'h0000_0000;
            w_strb_r <= 4'h0;
            bvalid_r <= 1'b0;
            bresp_r <= 2'h0;
            ctrl_r <= STOC_CTRL_RST;
            mode_r <= STOC_MODE_RST;
            behav_r <= STOC_BEHAV_RST;
            stop_time_r <= 32'(STOP_CYCLES);
        end else begin
            if (s_axi_awvalid && s_axi_awready && !wr_go) begin
                aw_held_r <= 1'b1;
                aw_addr_r <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready && !wr_go) begin
                w_held_r <= 1'b1;
                w_data_r <= s_axi_wdata;
                w_strb_r <= s_axi_wstrb;
            end
            if (wr_go) begin
                aw_held_r <= 1'b0;
                w_held_r <= 1'b0;
                bvalid_r <= 1'b1;
                bresp_r <= wr_hit ? 2'h0 : 2'h2;
            end else if (s_axi_bready) begin
                bvalid_r <= 1'b0;
            end
            if (wr_ctrl) ctrl_r <= stoc_merge(ctrl_r, wr_data, wr_strb) & 32'h0000_001F;
            if (wr_mode && cfg_open) mode_r <= mode_m[5:0];
            if (wr_behav && cfg_open) behav_r <= behav_m[5:0];
            if (wr_time) stop_time_r <= stoc_merge(stop_time_r, wr_data, wr_strb);
        end
    end

    // ************************************************************
    // Axis logic
    // ************************************************************
    stoc_ax_state_t ax_r [STOC_AXES];
    logic [31:0] stop_cnt_r [STOC_AXES];
    logic [STOC_AXES-1:0] off_vec;
    stoc_dev_state_t dev_r;
    wire any_err = err_s2_r[0] || err_s2_r[1] || fatal_r;

    // A fatal error latches until power is removed; reset does not clear it.
    always_ff @(posedge aclk) begin
        if (err_s2_r[1]) begin
            fatal_r <= 1'b1;
        end
    end

    for (genvar a = 0; a < STOC_AXES; a++) begin : g_axis
        stoc_axis_in_t pin;
        assign pin = stoc_axis_in_t'(in_s2_r[a]);
        // Requests are active low; a low level asks for the function.
        wire sto_req = !pin.torque_removal_request_in_n;
        wire ss1_req = !pin.controlled_stop_request_in_n;
        wire react_sto = ctrl_r[STOC_CTRL_RAMP_REACT0 + a];
        wire timeout = (stop_cnt_r[a] >= stop_time_r);
        wire go_off = sto_req || any_err || (pin.ramp_violation && react_sto);
        wire off = (ax_r[a] == STOC_AX_TORQUE_OFF);
        wire running = (dev_r == STOC_DEV_RUN) && !off;
        // Permanent guards ignore their request and are on at once.
        wire [5:0] g_active = perm_mask | (~perm_mask & ~pin.guard_request_n);
        wire brk_follow = ctrl_r[STOC_CTRL_BRK_FOLLOW0 + a];
        assign off_vec[a] = off;

        // Axis state; the stop timer counts only while stopping.
        always_ff @(posedge aclk) begin
            if (!aresetn) begin
                ax_r[a] <= STOC_AX_TORQUE_OFF;
                stop_cnt_r[a] <= 32'h0000_0000;
            end else begin
                case (ax_r[a])
                    STOC_AX_RUN: begin
                        stop_cnt_r[a] <= 32'h0000_0000;
                        if (go_off) ax_r[a] <= STOC_AX_TORQUE_OFF;
                        else if (ss1_req || pin.ramp_violation) ax_r[a] <= STOC_AX_STOPPING;
                    end
                    STOC_AX_STOPPING: begin
                        stop_cnt_r[a] <= stop_cnt_r[a] + 32'h0000_0001;
                        if (go_off || pin.standstill || timeout) begin
                            ax_r[a] <= STOC_AX_TORQUE_OFF;
                        end
                    end
                    STOC_AX_TORQUE_OFF: begin
                        stop_cnt_r[a] <= 32'h0000_0000;
                        // Release needs boot complete and the removal and stop requests withdrawn.
                        if (boot_done && cfg_ok && !go_off && !ss1_req) begin
                            ax_r[a] <= STOC_AX_RUN;
                        end
                    end
                    default: ax_r[a] <= STOC_AX_TORQUE_OFF;
                endcase
            end
        end

        // Outputs; each axis has its own dual-channel path.
        always_ff @(posedge aclk) begin
            if (!aresetn) begin
                // Reset shows the torque-off state, so the acknowledges stand high too.
                axis_out[a] <= '{torque_off_a: 1'b1, torque_off_b: 1'b1,
                    torque_removal_ack_out: 1'b1, controlled_stop_ack_out: 1'b1,
                    state: STOC_AX_TORQUE_OFF, default: '0};
            end else begin
                axis_out[a].torque_off_a <= off;
                axis_out[a].torque_off_b <= off;
                axis_out[a].torque_removal_ack_out <= off;
                axis_out[a].controlled_stop_ack_out <= off;
                axis_out[a].guard_ok <= running ? (g_active & pin.guard_in_limit)
                    : 6'h00;
                axis_out[a].brake_out <= off ? 1'b0
                    : (brk_follow ? pin.drive_brake_cmd : 1'b1);
                axis_out[a].brake_test_active_out <= pin.brake_test_running;
                axis_out[a].state <= ax_r[a];
            end
        end
    end

    // ************************************************************
    // Device state
    // ************************************************************
    // Startup holds until boot ends with a valid configuration and no error; all axes off means device torque-off.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            dev_r <= STOC_DEV_STARTUP;
        end else begin
            case (dev_r)
                STOC_DEV_STARTUP: begin
                    if (boot_done && cfg_ok && !any_err) dev_r <= STOC_DEV_RUN;
                end
                STOC_DEV_RUN: if (&off_vec) dev_r <= STOC_DEV_TORQUE_OFF;
                STOC_DEV_TORQUE_OFF: if (!(&off_vec)) dev_r <= STOC_DEV_RUN;
                default: dev_r <= STOC_DEV_STARTUP;
            endcase
        end
    end
    assign device_state = dev_r;

    // Read path, one-cycle answer.
    wire [31:0] status_w = {20'h0, 3'(ax_r[1]), 3'(ax_r[0]), fatal_r, cfg_ok, 1'b0, 3'(dev_r)};
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_r <= 1'b0;
            rdata_r <= 32'h0000_0000;
            rresp_r <= 2'h0;
        end else if (s_axi_arvalid && s_axi_arready) begin
            rvalid_r <= 1'b1;
            rresp_r <= 2'h0;
            case (s_axi_araddr)
                STOC_OFS_CTRL: rdata_r <= ctrl_r;
                STOC_OFS_MODE: rdata_r <= {26'h0, mode_r};
                STOC_OFS_BEHAV: rdata_r <= {26'h0, behav_r};
                STOC_OFS_STOPTIME: rdata_r <= stop_time_r;
                STOC_OFS_STATUS: rdata_r <= status_w;
                STOC_OFS_CFGERR: rdata_r <= {26'h0, cfg_bad};
                default: begin
                    rdata_r <= 32'h0000_0000;
                    rresp_r <= 2'h2;
                end
            endcase
        end else if (s_axi_rready) begin
            rvalid_r <= 1'b0;
        end
    end

endmodule

`default_nettype wire

// File: testbench/stoc_top_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module stoc_top_assertions
    import stoc_pkg::*;
#(
    parameter int STOP_CYCLES = STOC_STOP_CYCLES
) (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Bus answers
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Events, axes and device
    input wire logic global_error,
    input wire stoc_axis_in_t axis_in [STOC_AXES],
    input wire stoc_axis_out_t axis_out [STOC_AXES],
    input wire logic [2:0] device_state
);
    // ************************************************************
    // Device level checks
    // ************************************************************
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    // Both axes have torque off at once, checked on channel a only.
    sequence all_off_s;
        axis_out[0].torque_off_a && axis_out[1].torque_off_a;
    endsequence

    dev_all_off_a: assert property (device_state == STOC_DEV_TORQUE_OFF |-> all_off_s)
        else $error("device torque-off while an axis still has torque");
    global_off_a: assert property (global_error [*3] |-> ##[0:4] all_off_s)
        else $error("global error did not remove torque on all axes");
    startup_quiet_a: assert property (device_state == STOC_DEV_STARTUP |->
        axis_out[0].guard_ok == 6'h00 && axis_out[1].guard_ok == 6'h00)
        else $error("guard feedback high during startup");
    resp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
        else $error("write response dropped before it was taken");
    rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid)
        else $error("read data dropped before it was taken");

    // Per-axis checks; one lagging output register is tolerated where noted.
    for (genvar g = 0; g < STOC_AXES; g++) begin : g_ax
        paths_agree_a: assert property (axis_out[g].torque_off_a == axis_out[g].torque_off_b)
            else $error("shutdown channels of one axis disagree");
        removal_req_a: assert property (!axis_in[g].torque_removal_request_in_n [*6]
            |-> axis_out[g].torque_off_a)
            else $error("low removal request left torque on");
        state_follow_a: assert property ($rose(axis_out[g].torque_off_a)
            |-> ##[0:1] axis_out[g].state == STOC_AX_TORQUE_OFF)
            else $error("axis state not torque-off after removal");
        brake_engage_a: assert property (axis_out[g].torque_off_a [*2] |-> !axis_out[g].brake_out)
            else $error("brake released while torque removed");
        ack_high_a: assert property (axis_out[g].state == STOC_AX_TORQUE_OFF [*2] |->
            axis_out[g].torque_removal_ack_out && axis_out[g].controlled_stop_ack_out)
            else $error("acknowledge low in torque-off state");
        motion_quiet_a: assert property (axis_out[g].torque_off_a [*2]
            |-> axis_out[g].guard_ok == 6'h00)
            else $error("guard feedback high while torque removed");
    end
endmodule
`default_nettype wire

// File: testbench/stoc_ctrl_model.sv
`timescale 1ns/1ps
`default_nettype none
module stoc_ctrl_model (
    // Clock
    input wire logic aclk,
    // Bench requests, a one asks for the function
    input wire logic [1:0] off_req,
    input wire logic [1:0] stop_req,
    input wire logic [11:0] guard_req,
    // Fieldbus activation lines, low means active
    output var logic [1:0] off_n = 2'b11,
    output var logic [1:0] stop_n = 2'b11,
    output var logic [11:0] guard_n = 12'hFFF
);
    // The controller refreshes its lines once a bus cycle, so requests land a clock late.
    always @(posedge aclk) begin
        off_n <= ~off_req;
        stop_n <= ~stop_req;
        guard_n <= ~guard_req;
    end
endmodule
`default_nettype wire

// File: testbench/stoc_top_tb.sv
`timescale 1ns/1ps
`default_nettype none
module stoc_top_tb;
    import stoc_pkg::*;
    // ************************************************************
    // Bench signals
    // ************************************************************
    localparam int STOPN = 20;
    logic aclk = 1'b0, aresetn = 1'b0, gerr = 1'b0, ferr = 1'b0;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic awready, wready, bvalid, arready, rvalid;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h0, rdata, d;
    logic [1:0] bresp, rresp, r, torque_removal = 2'b00, ss = 2'b00, off_n, ss_n;
    logic [11:0] gd = 12'h000, gd_n;
    logic [2:0] dev;
    stoc_axis_in_t drv [STOC_AXES];
    stoc_axis_in_t axis_in [STOC_AXES];
    stoc_axis_out_t axis_out [STOC_AXES];
    int n_checks = 0, n_mismatch = 0, cyc = 0;

    stoc_ctrl_model stoc_ctrl_model_i (.aclk(aclk), .off_req(torque_removal), .stop_req(ss),
        .guard_req(gd), .off_n(off_n), .stop_n(ss_n), .guard_n(gd_n));
    stoc_top #(.STOP_CYCLES(STOPN)) stoc_top_i (.aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .global_error(gerr), .fatal_error(ferr), .axis_in(axis_in), .axis_out(axis_out),
        .device_state(dev));

    // Drive-side levels merged with the controller's activation lines.
    always_comb begin
        for (int g = 0; g < STOC_AXES; g++) begin
            axis_in[g] = drv[g];
            axis_in[g].torque_removal_request_in_n = off_n[g];
            axis_in[g].controlled_stop_request_in_n = ss_n[g];
            axis_in[g].guard_request_n = gd_n[g*6 +: 6];
        end
    end

    // Clock, and a watchdog so a hung handshake still ends in the verdict.
    initial begin
        forever #10 aclk = ~aclk;
    end
    always @(posedge aclk) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            n_mismatch++;
            give_verdict();
        end
    end

    // ************************************************************
    // Helpers
    // ************************************************************
    task give_verdict;
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    task chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task ax(input int g, input logic [2:0] st, input logic off, input logic [5:0] gok);
        chk(axis_out[g].state, st);
        chk(axis_out[g].torque_off_a, off);
        chk(axis_out[g].guard_ok, gok);
    endtask
    task settle(input int n);
        repeat (n) @(posedge aclk);
        #1;
    endtask
    // Address and data are offered together and each released once taken.
    task wr(input logic [7:0] a, input logic [31:0] v);
        logic aw, w;
        @(posedge aclk);
        awaddr <= a;
        wdata <= v;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        aw = 1'b0;
        w = 1'b0;
        while (!(aw && w)) begin
            @(posedge aclk);
            if (!aw && awready) begin
                aw = 1'b1;
                awvalid <= 1'b0;
            end
            if (!w && wready) begin
                w = 1'b1;
                wvalid <= 1'b0;
            end
        end
        do @(posedge aclk); while (!bvalid);
        r = bresp;
        bready <= 1'b0;
    endtask
    task rd(input logic [7:0] a);
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do @(posedge aclk); while (!arready);
        arvalid <= 1'b0;
        do @(posedge aclk); while (!rvalid);
        d = rdata;
        r = rresp;
        rready <= 1'b0;
    endtask

    // ************************************************************
    // Scenarios
    // ************************************************************
    task t_reset;
        settle(1);
        chk(dev, STOC_DEV_STARTUP);
        ax(0, STOC_AX_TORQUE_OFF, 1'b1, 6'h00);
        rd(STOC_OFS_CTRL);
        chk(d, STOC_CTRL_RST);
        rd(8'h18);
        chk(r, 2'h2);
    endtask
    // A permanent watch-only guard without hysteresis must be turned down.
    // No jolting commutation is modelled, so permanent guards are safe here.
    task t_config;
        wr(STOC_OFS_MODE, 32'h09);
        wr(STOC_OFS_BEHAV, 32'h00);
        rd(STOC_OFS_CFGERR);
        chk(d, 32'h08);
        wr(STOC_OFS_BEHAV, 32'h08);
        rd(STOC_OFS_CFGERR);
        chk(d, 32'h00);
        wr(STOC_OFS_STOPTIME, STOPN);
    endtask
    task t_run;
        wr(STOC_OFS_CTRL, 32'h19);
        settle(8);
        chk(dev, STOC_DEV_RUN);
        ax(1, STOC_AX_RUN, 1'b0, 6'h09);
        chk(axis_out[0].brake_out, 1'b1);
        @(posedge aclk);
        drv[0].guard_in_limit <= 6'h3E;
        settle(6);
        chk(axis_out[0].guard_ok, 6'h08);
        wr(STOC_OFS_MODE, 32'h00);
        rd(STOC_OFS_MODE);
        chk(d, 32'h09);
        drv[0].guard_in_limit <= 6'h3F;
        settle(6);
        chk(axis_out[0].guard_ok, 6'h09);
        // Axis 0 brake now follows the drive's brake command.
        wr(STOC_OFS_CTRL, 32'h1B);
        settle(6);
        chk(axis_out[0].brake_out, 1'b0);
        drv[0].drive_brake_cmd <= 1'b1;
        settle(6);
        chk(axis_out[0].brake_out, 1'b1);
    endtask
    task t_removal;
        torque_removal <= 2'b01;
        settle(7);
        ax(0, STOC_AX_TORQUE_OFF, 1'b1, 6'h00);
        ax(1, STOC_AX_RUN, 1'b0, 6'h09);
        chk(axis_out[0].brake_out, 1'b0);
        chk(dev, STOC_DEV_RUN);
        torque_removal <= 2'b00;
        settle(7);
        ax(0, STOC_AX_RUN, 1'b0, 6'h09);
    endtask
    // Axis 0 halts at standstill, axis 1 only when the stop time runs out.
    // Stop request and ramp violation of each axis are driven on the same axis index.
    task t_stop;
        ss <= 2'b11;
        drv[0].standstill <= 1'b1;
        settle(7);
        ax(0, STOC_AX_TORQUE_OFF, 1'b1, 6'h00);
        chk(axis_out[1].state, STOC_AX_STOPPING);
        settle(STOPN);
        ax(1, STOC_AX_TORQUE_OFF, 1'b1, 6'h00);
        ss <= 2'b00;
        drv[0].standstill <= 1'b0;
        settle(8);
        ss <= 2'b10;
        drv[1].ramp_violation <= 1'b1;
        settle(9);
        chk(axis_out[1].torque_off_a, 1'b1);
        ss <= 2'b00;
        drv[1].ramp_violation <= 1'b0;
        settle(8);
    endtask
    task t_errors;
        gerr <= 1'b1;
        drv[0].brake_test_running <= 1'b1;
        settle(7);
        chk(dev, STOC_DEV_TORQUE_OFF);
        ax(1, STOC_AX_TORQUE_OFF, 1'b1, 6'h00);
        chk(axis_out[0].brake_test_active_out, 1'b1);
        gerr <= 1'b0;
        ferr <= 1'b1;
        settle(5);
        ferr <= 1'b0;
        aresetn <= 1'b0;
        settle(3);
        aresetn <= 1'b1;
        wr(STOC_OFS_CTRL, 32'h19);
        settle(10);
        chk(axis_out[0].torque_off_a, 1'b1);
        rd(STOC_OFS_STATUS);
        chk(d[5], 1'b1);
    endtask

    initial begin
        foreach (drv[i]) begin
            drv[i] = '0;
            drv[i].guard_in_limit = 6'h3F;
        end
        repeat (5) @(posedge aclk);
        aresetn <= 1'b1;
        t_reset();
        t_config();
        t_run();
        t_removal();
        t_stop();
        t_errors();
        give_verdict();
    end
endmodule

bind stoc_top stoc_top_assertions #(.STOP_CYCLES(STOP_CYCLES)) stoc_top_assertions_i (
    .aclk(aclk), .aresetn(aresetn), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .global_error(global_error),
    .axis_in(axis_in), .axis_out(axis_out), .device_state(device_state));
`default_nettype wire
